//--- design/otp_prog_pkg.sv
// constants and types for the one-time-programmable code memory programming port
package otp_prog_pkg;
  localparam int ADDR_W      = 13;
  localparam int DATA_W      = 8;
  localparam int CODE_DEPTH  = 8192;
  localparam int ENC_DEPTH   = 64;
  localparam int ENC_AW      = 6;
  localparam int FIFO_DEPTH  = 32;
  localparam int LOW_ADDR_W  = 8;
  localparam int HIGH_ADDR_W = 5;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [2:0] LOCK_RESET  = 3'h7;
  // signature bytes, arbitrary values
  localparam logic [7:0] SIG_BYTE0 = 8'h5A;
  localparam logic [7:0] SIG_BYTE1 = 8'hA5;
  localparam logic [7:0] SIG_BYTE2 = 8'h3C;
  localparam logic [7:0] SIG_BYTE3 = 8'hC3;
  localparam logic [12:0] ENC_ADDR_LIMIT = 13'h003F;

  typedef enum logic [2:0] {
    MODE_IDLE   = 3'b000,
    MODE_PROG   = 3'b001,
    MODE_VERIFY = 3'b010,
    MODE_ENC    = 3'b011,
    MODE_SIG    = 3'b100,
    MODE_LOCK1  = 3'b101,
    MODE_LOCK2  = 3'b110,
    MODE_LOCK3  = 3'b111
  } prog_mode_t;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
    logic e;
  } mode_pins_t;

  typedef struct packed {
    prog_mode_t       mode;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } write_req_t;

  localparam int REQ_W = 3 + ADDR_W + DATA_W;
endpackage

//--- design/prog_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module prog_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input  wire logic             clock_in,
  input  wire logic             arst_n_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_r != (AW+1)'(DEPTH));
  assign out_valid_out = (count_r != '0);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_data_out  = mem_r[rd_ptr_r];

  always_ff @(posedge clock_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

//--- design/otp_code_programming_port.sv
// programming and verify port of the one-time-programmable code memory
`timescale 1ns/1ps
`default_nettype none
module otp_code_programming_port
  import otp_prog_pkg::*;
(
  input  wire logic                   clock_in,
  input  wire logic                   arst_n_in,
  input  wire logic                   reset_pin_in,
  input  wire logic                   program_store_enable_n_in,
  input  wire logic                   latch_enable_program_strobe_in,
  input  wire logic                   external_access_prog_supply_in,
  input  wire logic                   mode_select_a_in,
  input  wire logic                   mode_select_b_in,
  input  wire logic                   mode_select_c_in,
  input  wire logic                   mode_select_d_in,
  input  wire logic                   mode_select_e_in,
  input  wire logic [LOW_ADDR_W-1:0]  low_address_lines_in,
  input  wire logic [HIGH_ADDR_W-1:0] high_address_lines_in,
  input  wire logic [DATA_W-1:0]      program_data_lines_in,
  output logic      [DATA_W-1:0]      program_data_lines_out,
  output logic                        program_data_lines_oe_out,
  input  wire logic                   erase_in,
  output logic                        busy_out,
  output logic                        write_ready_out,
  output logic      [2:0]             lock_bits_out
);
  mode_pins_t        pins;
  prog_mode_t        mode;
  logic [ADDR_W-1:0] addr;
  logic              strobe_d_r;
  logic              strobe_fall;
  logic              entry_ok;
  write_req_t        req_in;
  write_req_t        req_out;
  logic              req_valid;
  logic              req_ready;
  logic [REQ_W-1:0]  req_bits;
  logic [DATA_W-1:0] code_mem_r [CODE_DEPTH];
  logic [DATA_W-1:0] enc_mem_r [ENC_DEPTH];
  logic [DATA_W-1:0] code_byte;
  logic [DATA_W-1:0] read_byte_nxt;
  logic [DATA_W-1:0] read_byte_r;
  logic              drive_nxt;
  logic              drive_r;
  logic [2:0]        lock_r;
  logic [ADDR_W:0]   erase_idx_r;
  logic              erasing;
  logic              erase_last;
  logic              code_we;
  logic              enc_we;

  function automatic prog_mode_t decode_mode(input mode_pins_t p, input logic hv);
    prog_mode_t m;
    m = MODE_IDLE;
    if (hv) begin
      case ({p.a, p.b, p.c, p.d, p.e})
        5'b01111: m = MODE_PROG;
        5'b01101: m = MODE_ENC;
        5'b11111: m = MODE_LOCK1;
        5'b11100: m = MODE_LOCK2;
        5'b10110: m = MODE_LOCK3;
        default:  m = MODE_IDLE;
      endcase
    end else begin
      if (!p.a && !p.c && p.d && p.e) begin
        m = MODE_VERIFY;
      end else if (!p.a && !p.c && !p.d && !p.e) begin
        m = MODE_SIG;
      end
    end
    return m;
  endfunction

  function automatic logic [DATA_W-1:0] sig_byte(input logic [1:0] k);
    case (k)
      2'h0:    return SIG_BYTE0;
      2'h1:    return SIG_BYTE1;
      2'h2:    return SIG_BYTE2;
      default: return SIG_BYTE3;
    endcase
  endfunction

  assign pins = '{a: mode_select_a_in, b: mode_select_b_in, c: mode_select_c_in,
                  d: mode_select_d_in, e: mode_select_e_in};
  // reset high and store enable low
  assign entry_ok = reset_pin_in && !program_store_enable_n_in;
  assign mode = entry_ok ? decode_mode(pins, external_access_prog_supply_in) : MODE_IDLE;
  assign addr = {high_address_lines_in, low_address_lines_in};

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strobe_d_r <= 1'b1;
    end else begin
      strobe_d_r <= latch_enable_program_strobe_in;
    end
  end

  assign strobe_fall = strobe_d_r && !latch_enable_program_strobe_in;
  assign erasing     = (erase_idx_r != '0);
  assign erase_last  = (erase_idx_r == (ADDR_W+1)'(CODE_DEPTH));

  always_comb begin
    req_in      = '0;
    req_in.mode = mode;
    req_in.addr = addr;
    req_in.data = program_data_lines_in;
  end

  assign req_valid       = strobe_fall && (mode != MODE_IDLE) && (mode != MODE_VERIFY)
                           && (mode != MODE_SIG);
  assign write_ready_out = req_ready;

  prog_fifo #(
    .WIDTH(REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_in     (clock_in),
    .arst_n_in    (arst_n_in),
    .in_data_in   (req_in),
    .in_valid_in  (req_valid),
    .in_ready_out (req_ready),
    .out_data_out (req_bits),
    .out_valid_out(busy_out),
    .out_ready_in (!erasing)
  );
  assign req_out = req_bits;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      erase_idx_r <= '0;
    end else if (erasing) begin
      erase_idx_r <= erase_last ? '0 : erase_idx_r + 1'b1;
    end else if (erase_in) begin
      erase_idx_r <= (ADDR_W+1)'(1);
    end
  end

  assign code_we = busy_out && !erasing && (req_out.mode == MODE_PROG);
  assign enc_we  = busy_out && !erasing && (req_out.mode == MODE_ENC) &&
                   (req_out.addr <= ENC_ADDR_LIMIT);

  // code array storage
  always_ff @(posedge clock_in) begin
    if (erasing) begin
      code_mem_r[erase_idx_r[ADDR_W-1:0] - 1'b1] <= ERASED_BYTE;
    end else if (code_we) begin
      code_mem_r[req_out.addr] <= req_out.data;
    end
  end

  // encryption array storage
  always_ff @(posedge clock_in) begin
    if (erasing) begin
      enc_mem_r[erase_idx_r[ENC_AW-1:0]] <= ERASED_BYTE;
    end else if (enc_we) begin
      enc_mem_r[req_out.addr[ENC_AW-1:0]] <= req_out.data;
    end
  end

  // lock bits, cleared by programming
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lock_r <= LOCK_RESET;
    end else if (erasing) begin
      lock_r <= LOCK_RESET;
    end else if (busy_out) begin
      case (req_out.mode)
        MODE_LOCK1: lock_r[0] <= 1'b0;
        MODE_LOCK2: lock_r[1] <= 1'b0;
        MODE_LOCK3: lock_r[2] <= 1'b0;
        default:    lock_r    <= lock_r;
      endcase
    end
  end
  assign lock_bits_out = lock_r;

  assign code_byte = code_mem_r[addr] ^ ~enc_mem_r[addr[ENC_AW-1:0]];

  always_comb begin
    read_byte_nxt = '0;
    drive_nxt     = 1'b0;
    case (mode)
      MODE_VERIFY: begin
        // verify read enabled by select b low
        read_byte_nxt = code_byte;
        drive_nxt     = !mode_select_b_in;
      end
      MODE_SIG: begin
        read_byte_nxt = sig_byte(addr[1:0]);
        drive_nxt = !mode_select_b_in;
      end
      default: begin
        read_byte_nxt = '0;
        drive_nxt     = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      read_byte_r <= '0;
      drive_r     <= 1'b0;
    end else begin
      read_byte_r <= read_byte_nxt;
      drive_r     <= drive_nxt;
    end
  end

  assign program_data_lines_out    = read_byte_r;
  assign program_data_lines_oe_out = drive_r;
endmodule
`default_nettype wire

//--- dv/otp_port_assertions.sv
// pin-level assertions for the programming port
`timescale 1ns/1ps
`default_nettype none
module otp_port_assertions
  import otp_prog_pkg::*;
(
  input wire logic       clock_in,
  input wire logic       arst_n_in,
  input wire logic       reset_pin_in,
  input wire logic       program_store_enable_n_in,
  input wire logic       latch_enable_program_strobe_in,
  input wire logic       external_access_prog_supply_in,
  input wire logic       mode_select_a_in,
  input wire logic       mode_select_b_in,
  input wire logic       mode_select_c_in,
  input wire logic       mode_select_d_in,
  input wire logic       mode_select_e_in,
  input wire logic [7:0] low_address_lines_in,
  input wire logic [7:0] program_data_lines_out,
  input wire logic       program_data_lines_oe_out,
  input wire logic       busy_out,
  input wire logic       write_ready_out,
  input wire logic [2:0] lock_bits_out
);
  wire logic       ok = reset_pin_in && !program_store_enable_n_in;
  wire logic       hv = external_access_prog_supply_in;
  wire logic       st = latch_enable_program_strobe_in;
  wire logic       oe = program_data_lines_oe_out;
  wire logic [4:0] pins = {mode_select_a_in, mode_select_b_in, mode_select_c_in,
                           mode_select_d_in, mode_select_e_in};
  wire logic [3:0] rd = {pins[4], pins[2:0]};
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  function automatic logic [7:0] sig_of(input logic [1:0] k);
    return k == 2'h0 ? SIG_BYTE0 : k == 2'h1 ? SIG_BYTE1 : k == 2'h2 ? SIG_BYTE2 : SIG_BYTE3;
  endfunction
  sequence s_fall;
    $past(st) && !st;
  endsequence
  sequence s_take(logic [4:0] m);
    ok && hv && pins == m && write_ready_out;
  endsequence
  property p_oe_verify; ok && !hv && rd == 4'h3 && !mode_select_b_in |=> oe; endproperty
  a_oe_verify: assert property (p_oe_verify) else $error("oe missing in verify");
  property p_oe_off; mode_select_b_in |=> !oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe while b high");
  property p_oe_write; hv |=> !oe; endproperty
  a_oe_write: assert property (p_oe_write) else $error("oe under high supply");
  property p_sig; ok && !hv && rd == 4'h0 && !mode_select_b_in
    |=> program_data_lines_out == sig_of($past(low_address_lines_in[1:0])); endproperty
  a_sig: assert property (p_sig) else $error("signature byte wrong");
  property p_push; s_take(5'h0F) ##0 s_fall |=> busy_out; endproperty
  a_push: assert property (p_push) else $error("strobe not queued");
  property p_rise; $rose(busy_out) |-> $past(st, 2) && !$past(st); endproperty
  a_rise: assert property (p_rise) else $error("write without strobe");
  property p_full; !write_ready_out |-> busy_out; endproperty
  a_full: assert property (p_full) else $error("full but empty");
  property p_lock1; s_take(5'h1F) ##0 s_fall ##0 !busy_out |-> ##[1:3] !lock_bits_out[0];
  endproperty
  a_lock1: assert property (p_lock1) else $error("lock one not set");
endmodule
bind otp_code_programming_port otp_port_assertions u_otp_port_assertions (.clock_in,
  .arst_n_in, .reset_pin_in, .program_store_enable_n_in, .latch_enable_program_strobe_in,
  .external_access_prog_supply_in, .mode_select_a_in, .mode_select_b_in, .mode_select_c_in,
  .mode_select_d_in, .mode_select_e_in, .low_address_lines_in, .program_data_lines_out,
  .program_data_lines_oe_out, .busy_out, .write_ready_out, .lock_bits_out);
`default_nettype wire

//--- dv/otp_programmer_model.sv
// programmer model driving mode, address, data and strobe pins
`timescale 1ns/1ps
`default_nettype none
module otp_programmer_model
  import otp_prog_pkg::*;
(
  input  wire logic   clock_in,
  output logic        strobe_out,
  output logic        supply_out,
  output mode_pins_t  pins_out,
  output logic [12:0] addr_out,
  output logic [7:0]  data_out
);
  initial begin
    strobe_out = 1'b1;
    supply_out = 1'b0;
    pins_out = '0;
    addr_out = '0;
    data_out = '0;
  end
  task automatic write_byte(input mode_pins_t p, input logic [12:0] a, input logic [7:0] d);
    @(negedge clock_in);
    pins_out = p;
    addr_out = a;
    data_out = d;
    @(negedge clock_in);
    supply_out = 1'b1;
    @(negedge clock_in);
    strobe_out = 1'b0;
    @(negedge clock_in);
    strobe_out = 1'b1;
    @(negedge clock_in);
    supply_out = 1'b0;
  endtask
  task automatic read_mode(input mode_pins_t p, input logic [12:0] a);
    @(negedge clock_in);
    pins_out = p;
    addr_out = a;
    data_out = ~data_out;
  endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the programming port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import otp_prog_pkg::*;
  localparam mode_pins_t PROG = 5'h0F, VER = 5'h03, SIG = 5'h00, ENC = 5'h0D;
  localparam mode_pins_t LOCKS [3] = '{5'h1F, 5'h1C, 5'h16};
  localparam logic [7:0] SIGS [4] = '{SIG_BYTE0, SIG_BYTE1, SIG_BYTE2, SIG_BYTE3};
  logic        clock_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        erase = 1'b0;
  logic        rst_pin = 1'b1;
  logic        program_store_enable_n_n = 1'b0;
  logic        strobe, supply, oe, busy, ready;
  mode_pins_t  pins;
  logic [12:0] a;
  logic [12:0] addr;
  logic [7:0]  d, wdata, dout, dbus;
  logic [2:0]  lock;
  logic [2:0]  lk = 3'h7;
  logic [7:0]  mem [8192];
  logic [7:0]  enc [64];
  int          num_errors = 0;
  int          checks = 0;
  int          cyc = 0;
  assign dbus = oe ? dout : wdata;
  always #2 clock_in = ~clock_in;
  otp_programmer_model u_otp_programmer_model (.clock_in, .strobe_out(strobe),
    .supply_out(supply), .pins_out(pins), .addr_out(addr), .data_out(wdata));
  otp_code_programming_port u_otp_code_programming_port (.clock_in, .arst_n_in,
    .reset_pin_in(rst_pin), .program_store_enable_n_in(program_store_enable_n_n),
    .latch_enable_program_strobe_in(strobe), .external_access_prog_supply_in(supply),
    .mode_select_a_in(pins.a), .mode_select_b_in(pins.b), .mode_select_c_in(pins.c),
    .mode_select_d_in(pins.d), .mode_select_e_in(pins.e),
    .low_address_lines_in(addr[7:0]), .high_address_lines_in(addr[12:8]),
    .program_data_lines_in(dbus), .program_data_lines_out(dout),
    .program_data_lines_oe_out(oe), .erase_in(erase), .busy_out(busy),
    .write_ready_out(ready), .lock_bits_out(lock));
  function automatic logic [7:0] exp_rd(input logic [12:0] x);
    return mem[x] ^ ~enc[x[5:0]];
  endfunction
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input mode_pins_t p, input logic [12:0] x, input logic [7:0] v);
    u_otp_programmer_model.write_byte(p, x, v);
  endtask
  task automatic rd(input mode_pins_t p, input logic [12:0] x, input logic [7:0] e);
    u_otp_programmer_model.read_mode(p, x);
    @(negedge clock_in);
    chk("data", e, dout);
    chk("oe", {7'h00, !p.b}, {7'h00, oe});
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    foreach (mem[i]) mem[i] = ERASED_BYTE;
    foreach (enc[i]) enc[i] = ERASED_BYTE;
    void'($urandom(32'h257B096D));
    repeat (10) @(negedge clock_in);
    chk("lock", 8'h07, {5'h00, lock});
    chk("busy oe ready", 8'h01, {5'h00, busy, oe, ready});
    arst_n_in = 1'b1;
    erase = 1'b1;
    @(negedge clock_in);
    erase = 1'b0;
    for (int i = 0; i < 32; i++) begin
      d = 8'($urandom);
      mem[13'h1FE0 + 13'(i)] = d;
      wr(PROG, 13'h1FE0 + 13'(i), d);
    end
    chk("ready", 8'h00, {7'h00, ready});
    wr(PROG, 13'h0000, 8'h00);
    repeat (8300) @(negedge clock_in);
    chk("busy", 8'h00, {7'h00, busy});
    for (int i = 0; i < 32; i++) rd(VER, 13'h1FE0 + 13'(i), exp_rd(13'h1FE0 + 13'(i)));
    rd(VER, 13'h0000, ERASED_BYTE);
    for (int i = 1; i < 16; i++) begin
      a = {1'b0, 4'(i), 8'($urandom)};
      d = 8'($urandom);
      mem[a] = d;
      wr(PROG, a, d);
      rd(VER, a, exp_rd(a));
    end
    u_otp_programmer_model.read_mode(5'h0B, 13'h1FE0);
    @(negedge clock_in);
    chk("oe", 8'h00, {7'h00, oe});
    for (int k = 0; k < 4; k++) rd(SIG, 13'(k), SIGS[k]);
    d = 8'($urandom);
    wr(ENC, 13'h0066, 8'h00);
    wr(ENC, 13'h0025, d);
    enc[6'h25] = d;
    repeat (2) @(negedge clock_in);
    rd(VER, 13'h1FE5, exp_rd(13'h1FE5));
    rd(VER, 13'h1FE6, exp_rd(13'h1FE6));
    for (int k = 0; k < 3; k++) begin
      wr(LOCKS[k], 13'h0000, 8'h00);
      repeat (2) @(negedge clock_in);
      lk[k] = 1'b0;
      chk("lock", {5'h00, lk}, {5'h00, lock});
    end
    program_store_enable_n_n = 1'b1;
    wr(PROG, 13'h1FE7, ~mem[13'h1FE7]);
    program_store_enable_n_n = 1'b0;
    rd(VER, 13'h1FE7, exp_rd(13'h1FE7));
    rst_pin = 1'b0;
    u_otp_programmer_model.read_mode(VER, 13'h1FE7);
    @(negedge clock_in);
    chk("oe", 8'h00, {7'h00, oe});
    chk("data", 8'h00, dout);
    rst_pin = 1'b1;
    erase = 1'b1;
    @(negedge clock_in);
    erase = 1'b0;
    repeat (8200) @(negedge clock_in);
    chk("lock", 8'h07, {5'h00, lock});
    rd(VER, 13'h1FE5, ERASED_BYTE);
    results();
  end
endmodule
`default_nettype wire
